// ==== core/tsq_defs.svh ====
`ifndef TSQ_DEFS_SVH
`define TSQ_DEFS_SVH
// Register byte offsets
`define TSQ_OFF_CTRL        8'h00
`define TSQ_OFF_STATUS      8'h04
`define TSQ_OFF_STEP        8'h08
`define TSQ_OFF_ADJ         8'h0c
`define TSQ_OFF_HOLD        8'h10
`define TSQ_OFF_LIM0        8'h14
`define TSQ_OFF_LIM5        8'h28
`define TSQ_OFF_BTE         8'h2c
`define TSQ_OFF_CNT0        8'h30
`define TSQ_OFF_CNT1        8'h34
`define TSQ_OFF_ADCSEL      8'h38
// Command classes
`define TSQ_CMD_CTRL        4'h0
`define TSQ_CMD_ADDCP       4'h1
`define TSQ_CMD_WHI         4'h4
`define TSQ_CMD_WLO         4'h5
`define TSQ_CMD_IRQ         4'h7
`define TSQ_CMD_TRIG        3'h4
// Control step options
`define TSQ_OPT_SD_OFF      4'h2
`define TSQ_OPT_SD_ON       4'h6
`define TSQ_OPT_TMR0        4'h8
`define TSQ_OPT_TMR1        4'h9
`define TSQ_OPT_SWT         4'hb
`define TSQ_OPT_LD_C0       4'hc
`define TSQ_OPT_LD_C1       4'hd
`define TSQ_OPT_LD_LIT      4'he
`define TSQ_OPT_BCAST       4'hf
// Add, copy and interrupt option ranges
`define TSQ_OPT_ADD_LAST    4'h5
`define TSQ_OPT_COPY_FIRST  4'h8
`define TSQ_OPT_COPY_LAST   4'hd
`define TSQ_OPT_IRQ_LAST    4'h3
// Field positions and table slots
`define TSQ_CTRL_SWT_BIT    0
`define TSQ_CTRL_SDEN_BIT   1
`define TSQ_LIM_T0          3'h2
`define TSQ_LIM_T1          3'h3
`define TSQ_LIM_SD          3'h4
`define TSQ_LIM_LIT         3'h5
// Reset values
`define TSQ_RST_WORD        16'h0000
`define TSQ_RST_BTE         32'h00000000
`define TSQ_RST_SDEN        1'b0
`endif

// ==== core/tsq_pkg.sv ====
package tsq_pkg;
	// Sequencer phases
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_EXEC,
		ST_WAIT_EDGE,
		ST_WAIT_TMR,
		ST_WAIT_SWT,
		ST_DELAY
	} tsq_state_t;
	typedef logic [15:0] tsq_word_t;
endpackage

// ==== core/tsq_edge_sync.sv ====
`timescale 1ns/100ps
module tsq_edge_sync #(
	parameter int N = 16                // Number of sources
) (
	input  wire logic         clock,    // Peripheral clock
	input  wire logic         rstn,     // Synchronous reset, active low
	input  wire logic [N-1:0] srcIn,    // Sources from other domains
	output logic      [N-1:0] rise,     // Low-to-high pulse
	output logic      [N-1:0] fall      // High-to-low pulse
);
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : gSrc
			logic metaQ;
			logic syncQ;
			logic prevQ;
			// Stage one is read by stage two only
			always_ff @(posedge clock) begin
				if (!rstn) begin
					metaQ <= 1'b0;
					syncQ <= 1'b0;
					prevQ <= 1'b0;
				end else begin
					metaQ <= srcIn[g];
					syncQ <= metaQ;
					prevQ <= syncQ;
				end
			end
			// Edges seen after the second stage
			assign rise[g] = syncQ && !prevQ;
			assign fall[g] = !syncQ && prevQ;
		end
	endgenerate
endmodule

// ==== core/tsq_timer.sv ====
`timescale 1ns/100ps
module tsq_timer #(
	parameter int W = 16                // Counter width
) (
	input  wire logic         clock,    // Peripheral clock
	input  wire logic         rstn,     // Synchronous reset, active low
	input  wire logic         start,    // Restart from zero
	input  wire logic [W-1:0] limit,    // Match value
	output logic              done      // High for the one cycle the count reaches limit
);
	logic [W-1:0] count_q;
	logic         running_q;

	// Counts up from zero, stops on the match
	always_ff @(posedge clock) begin
		if (!rstn) begin
			running_q <= 1'b0;
			count_q   <= '0;
		end else if (start) begin
			running_q <= 1'b1;
			count_q   <= '0;
		end else if (running_q) begin
			if (count_q == limit) begin
				running_q <= 1'b0;
			end else begin
				count_q <= W'(count_q + 1'b1);
			end
		end
	end

	// Limit is read live, so a lowered limit below the count matches only after the count wraps
	assign done = running_q && (count_q == limit);
endmodule

// ==== core/tsq_sequencer.sv ====
`timescale 1ns/100ps
`include "tsq_defs.svh"
// Overview of operation
// [RQ1] Upper step nibble selects command class
// [RQ2] Wait steps stall until selected edge
// [RQ3] Codes 100x form five-bit output selector
// [RQ4] Control 0010 stops, 0110 resumes step delay
// [RQ5] Control 1000/1001 start timer, wait match
// [RQ6] Control 1011 waits software bit rising
// [RQ7] Control 1100-1110 load ADC channel select
// [RQ8] Control 1111 fires all broadcast-enabled triggers
// [RQ9] Add options 0-5 add adjust value
// [RQ10] Copy options 8-13 copy hold value
// [RQ11] Reserved codes consume step, change nothing
// [RQ12] Wait options 0-9 pick PWM, compare, capture
// [RQ13] Wait options 10-15 comparators, ADC, external
// [RQ14] Interrupt options 0-3 pulse one interrupt
// [RQ15] Trigger step pulses one selected output
module tsq_sequencer (
	input  wire logic               clock,        // Peripheral clock, 250 MHz
	input  wire logic               rstn,         // Synchronous reset, active low
	input  wire logic               hsel,         // AHB-Lite select
	input  wire logic [31:0]        haddr,        // Byte address
	input  wire logic [1:0]         htrans,       // Transfer type
	input  wire logic               hwrite,       // Write when high
	input  wire logic [2:0]         hsize,        // Word transfers only
	input  wire logic [31:0]        hwdata,       // Write data
	input  wire logic               hready,       // Bus ready
	output logic                    hreadyout,    // Slave ready
	output logic                    hresp,        // Always OKAY
	output logic [31:0]             hrdata,       // Read data
	input  wire logic [15:0]        waitSrc,      // Peripheral edge sources
	output logic [31:0]             trigOut,      // Trigger outputs 0 to 31
	output logic [3:0]              seqIrq,       // Sequencer interrupts 0 to 3
	output tsq_pkg::tsq_word_t      adcChanSel,   // ADC channel select
	output logic                    adcChanLoad   // Pulse when channel select loads
);
	import tsq_pkg::*;

	tsq_state_t state_q;
	logic [7:0] step_q;
	logic [3:0] cmd;
	logic [3:0] opt;
	logic [2:0] tgtIdx;
	tsq_word_t  lim_q [0:5];
	tsq_word_t  adj_q;
	tsq_word_t  hold_q;
	tsq_word_t  cnt0_q;
	tsq_word_t  cnt1_q;
	logic [31:0] bte_q;
	logic       swt_q;
	logic       swtPrev_q;
	logic       swtRise;
	logic       sdEn_q;
	logic       sdEn_d;
	logic       exec;
	logic       isCtrl;
	logic       isAdd;
	logic       isCopy;
	logic       isWait;
	logic       isIrq;
	logic       isTrig;
	logic       isTmr;
	logic       isSwt;
	logic       stepDone;
	logic       edgeHit;
	logic       tmr0Start;
	logic       tmr1Start;
	logic       sdStart;
	logic       tmr0Done;
	logic       tmr1Done;
	logic       sdDone;
	logic [15:0] srcRise;
	logic [15:0] srcFall;
	logic       accept;
	logic       wrValid_q;
	logic [7:0] wrAddr_q;
	logic [2:0] wrIdx;
	logic       stepWr;
	logic       limWr;
	logic [2:0] rdIdx;
	logic [31:0] rdData;
	logic [31:0] hrdata_q;
	logic       hreadyout_q;
	logic [31:0] trigOut_q;
	logic [3:0] seqIrq_q;
	tsq_word_t  adcSel_q;
	logic       adcLoad_q;

	// Step decode
	assign cmd    = step_q[7:4];
	assign opt    = step_q[3:0];
	assign tgtIdx = step_q[2:0];
	assign exec   = (state_q == ST_EXEC);
	assign isCtrl = (cmd == `TSQ_CMD_CTRL); // [RQ1]
	assign isAdd  = (cmd == `TSQ_CMD_ADDCP) && (opt <= `TSQ_OPT_ADD_LAST); // [RQ9]
	assign isCopy = (cmd == `TSQ_CMD_ADDCP) && (opt >= `TSQ_OPT_COPY_FIRST)
		&& (opt <= `TSQ_OPT_COPY_LAST); // [RQ10]
	assign isWait = (cmd == `TSQ_CMD_WHI) || (cmd == `TSQ_CMD_WLO); // [RQ1]
	assign isIrq  = (cmd == `TSQ_CMD_IRQ); // [RQ1]
	assign isTrig = (cmd[3:1] == `TSQ_CMD_TRIG); // [RQ3]
	assign isTmr  = isCtrl && ((opt == `TSQ_OPT_TMR0) || (opt == `TSQ_OPT_TMR1));
	assign isSwt  = isCtrl && (opt == `TSQ_OPT_SWT);

	// Option picks one of sixteen sources, command picks the edge
	assign edgeHit = (cmd == `TSQ_CMD_WHI) ? srcRise[opt] : srcFall[opt]; // [RQ2] [RQ12] [RQ13]

	// Peripheral sources cross in through two flip-flops first
	tsq_edge_sync #(
		.N      (16)
	) uSync (
		.clock  (clock),
		.rstn   (rstn),
		.srcIn  (waitSrc),
		.rise   (srcRise),
		.fall   (srcFall)
	);

	// Timer 0, timer 1 and the step delay share one counter design
	assign tmr0Start = exec && isCtrl && (opt == `TSQ_OPT_TMR0); // [RQ5]
	assign tmr1Start = exec && isCtrl && (opt == `TSQ_OPT_TMR1); // [RQ5]
	assign sdStart   = stepDone && sdEn_d;

	tsq_timer #(
		.W      (16)
	) uTmr0 (
		.clock  (clock),
		.rstn   (rstn),
		.start  (tmr0Start),
		.limit  (lim_q[`TSQ_LIM_T0]),
		.done   (tmr0Done)
	);

	tsq_timer #(
		.W      (16)
	) uTmr1 (
		.clock  (clock),
		.rstn   (rstn),
		.start  (tmr1Start),
		.limit  (lim_q[`TSQ_LIM_T1]),
		.done   (tmr1Done)
	);

	tsq_timer #(
		.W      (16)
	) uDelay (
		.clock  (clock),
		.rstn   (rstn),
		.start  (sdStart),
		.limit  (lim_q[`TSQ_LIM_SD]),
		.done   (sdDone)
	);

	// Step delay enable as seen at the end of this step
	always_comb begin
		sdEn_d = sdEn_q;
		if (exec && isCtrl && (opt == `TSQ_OPT_SD_OFF)) begin
			sdEn_d = 1'b0; // [RQ4]
		end else if (exec && isCtrl && (opt == `TSQ_OPT_SD_ON)) begin
			sdEn_d = 1'b1; // [RQ4]
		end
	end

	// Completion of the current step
	always_comb begin
		stepDone = 1'b0;
		case (state_q)
			ST_EXEC: begin
				stepDone = !(isWait || isTmr || isSwt); // [RQ11]
			end
			ST_WAIT_EDGE: begin
				stepDone = edgeHit; // [RQ2]
			end
			ST_WAIT_TMR: begin
				stepDone = opt[0] ? tmr1Done : tmr0Done; // [RQ5]
			end
			ST_WAIT_SWT: begin
				stepDone = swtRise; // [RQ6]
			end
			default: begin
				stepDone = 1'b0;
			end
		endcase
	end

	// Sequencer phases; a step is taken only while idle
	always_ff @(posedge clock) begin
		if (!rstn) begin
			state_q <= ST_IDLE;
			step_q  <= 8'h00;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (stepWr) begin
						step_q  <= hwdata[7:0];
						state_q <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					if (isWait) begin
						state_q <= ST_WAIT_EDGE; // [RQ2]
					end else if (isTmr) begin
						state_q <= ST_WAIT_TMR; // [RQ5]
					end else if (isSwt) begin
						state_q <= ST_WAIT_SWT; // [RQ6]
					end else begin
						state_q <= sdEn_d ? ST_DELAY : ST_IDLE;
					end
				end
				ST_WAIT_EDGE, ST_WAIT_TMR, ST_WAIT_SWT: begin
					if (stepDone) begin
						state_q <= sdEn_d ? ST_DELAY : ST_IDLE;
					end
				end
				ST_DELAY: begin
					if (sdDone) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Step delay enable and software trigger history
	always_ff @(posedge clock) begin
		if (!rstn) begin
			sdEn_q    <= `TSQ_RST_SDEN;
			swtPrev_q <= 1'b0;
		end else begin
			sdEn_q    <= sdEn_d; // [RQ4]
			swtPrev_q <= swt_q;
		end
	end
	assign swtRise = swt_q && !swtPrev_q; // [RQ6]

	// AHB-Lite address phase; zero wait states, non-word sizes ignored
	assign accept = hsel && htrans[1] && hready && (hsize == 3'h2);
	assign wrIdx  = 3'((wrAddr_q - `TSQ_OFF_LIM0) >> 2);
	assign stepWr = wrValid_q && (wrAddr_q == `TSQ_OFF_STEP) && (state_q == ST_IDLE);
	assign limWr  = wrValid_q && (wrAddr_q >= `TSQ_OFF_LIM0) && (wrAddr_q <= `TSQ_OFF_LIM5);

	always_ff @(posedge clock) begin
		if (!rstn) begin
			wrValid_q   <= 1'b0;
			wrAddr_q    <= 8'h00;
			hrdata_q    <= 32'h00000000;
			hreadyout_q <= 1'b1;
		end else begin
			hreadyout_q <= 1'b1;
			wrValid_q   <= accept && hwrite && (haddr[31:8] == 24'h000000);
			if (accept) begin
				wrAddr_q <= haddr[7:0];
			end
			if (accept && !hwrite) begin
				hrdata_q <= rdData;
			end
		end
	end
	assign hreadyout = hreadyout_q;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;

	// Read decode; unmapped words read zero
	always_comb begin
		rdIdx  = 3'((haddr[7:0] - `TSQ_OFF_LIM0) >> 2);
		rdData = 32'h00000000;
		if (haddr[31:8] != 24'h000000) begin
			rdData = 32'h00000000;
		end else if (haddr[7:0] == `TSQ_OFF_CTRL) begin
			rdData = {30'h00000000, sdEn_q, swt_q};
		end else if (haddr[7:0] == `TSQ_OFF_STATUS) begin
			rdData = {29'h00000000, state_q};
		end else if (haddr[7:0] == `TSQ_OFF_STEP) begin
			rdData = {24'h000000, step_q};
		end else if (haddr[7:0] == `TSQ_OFF_ADJ) begin
			rdData = {16'h0000, adj_q};
		end else if (haddr[7:0] == `TSQ_OFF_HOLD) begin
			rdData = {16'h0000, hold_q};
		end else if ((haddr[7:0] >= `TSQ_OFF_LIM0) && (haddr[7:0] <= `TSQ_OFF_LIM5)) begin
			rdData = {16'h0000, lim_q[rdIdx]};
		end else if (haddr[7:0] == `TSQ_OFF_BTE) begin
			rdData = bte_q;
		end else if (haddr[7:0] == `TSQ_OFF_CNT0) begin
			rdData = {16'h0000, cnt0_q};
		end else if (haddr[7:0] == `TSQ_OFF_CNT1) begin
			rdData = {16'h0000, cnt1_q};
		end else if (haddr[7:0] == `TSQ_OFF_ADCSEL) begin
			rdData = {16'h0000, adcSel_q};
		end
	end

	// Software registers; an add or copy step wins over a bus write
	always_ff @(posedge clock) begin
		if (!rstn) begin
			for (int i = 0; i < 6; i++) begin
				lim_q[i] <= `TSQ_RST_WORD;
			end
			adj_q  <= `TSQ_RST_WORD;
			hold_q <= `TSQ_RST_WORD;
			cnt0_q <= `TSQ_RST_WORD;
			cnt1_q <= `TSQ_RST_WORD;
			bte_q  <= `TSQ_RST_BTE;
			swt_q  <= 1'b0;
		end else begin
			if (wrValid_q) begin
				if (wrAddr_q == `TSQ_OFF_CTRL) begin
					swt_q <= hwdata[`TSQ_CTRL_SWT_BIT];
				end else if (wrAddr_q == `TSQ_OFF_ADJ) begin
					adj_q <= hwdata[15:0];
				end else if (wrAddr_q == `TSQ_OFF_HOLD) begin
					hold_q <= hwdata[15:0];
				end else if (limWr) begin
					lim_q[wrIdx] <= hwdata[15:0];
				end else if (wrAddr_q == `TSQ_OFF_BTE) begin
					bte_q <= hwdata;
				end else if (wrAddr_q == `TSQ_OFF_CNT0) begin
					cnt0_q <= hwdata[15:0];
				end else if (wrAddr_q == `TSQ_OFF_CNT1) begin
					cnt1_q <= hwdata[15:0];
				end
			end
			if (exec && isAdd) begin
				lim_q[tgtIdx] <= 16'(lim_q[tgtIdx] + adj_q); // [RQ9]
			end else if (exec && isCopy) begin
				lim_q[tgtIdx] <= hold_q; // [RQ10]
			end
		end
	end

	// Peripheral outputs; pulses last one clock
	always_ff @(posedge clock) begin
		if (!rstn) begin
			trigOut_q <= 32'h00000000;
			seqIrq_q  <= 4'h0;
			adcSel_q  <= `TSQ_RST_WORD;
			adcLoad_q <= 1'b0;
		end else begin
			trigOut_q <= 32'h00000000;
			seqIrq_q  <= 4'h0;
			adcLoad_q <= 1'b0;
			if (exec && isTrig) begin
				trigOut_q <= 32'h00000001 << {cmd[0], opt}; // [RQ3] [RQ15]
			end else if (exec && isCtrl && (opt == `TSQ_OPT_BCAST)) begin
				trigOut_q <= bte_q; // [RQ8]
			end
			if (exec && isIrq && (opt <= `TSQ_OPT_IRQ_LAST)) begin
				seqIrq_q <= 4'h1 << opt[1:0]; // [RQ14]
			end
			if (exec && isCtrl && (opt >= `TSQ_OPT_LD_C0) && (opt <= `TSQ_OPT_LD_LIT)) begin
				adcLoad_q <= 1'b1; // [RQ7]
				if (opt == `TSQ_OPT_LD_C0) begin
					adcSel_q <= cnt0_q;
				end else if (opt == `TSQ_OPT_LD_C1) begin
					adcSel_q <= cnt1_q;
				end else begin
					adcSel_q <= lim_q[`TSQ_LIM_LIT];
				end
			end
		end
	end
	assign trigOut     = trigOut_q;
	assign seqIrq      = seqIrq_q;
	assign adcChanSel  = adcSel_q;
	assign adcChanLoad = adcLoad_q;

	// Checks next to the logic they guard
	trig_one_hot_a: assert property (@(posedge clock) disable iff (!rstn) // [RQ15]
		exec && isTrig |=> (trigOut == (32'h00000001 << step_q[4:0])) ##1 (trigOut == 32'h0))
		else $error("trigger step did not pulse exactly one output");

	irq_pulse_a: assert property (@(posedge clock) disable iff (!rstn) // [RQ14]
		exec && isIrq |=> seqIrq == ((step_q[3:0] <= 4'h3) ? (4'h1 << step_q[1:0]) : 4'h0))
		else $error("interrupt step drove wrong interrupt");

	bcast_trig_a: assert property (@(posedge clock) disable iff (!rstn) // [RQ8]
		exec && isCtrl && (opt == 4'hf) |=> trigOut == $past(bte_q))
		else $error("broadcast step did not follow enable register");

	adc_load_a: assert property (@(posedge clock) disable iff (!rstn) // [RQ7]
		exec && isCtrl && (opt == 4'he) |=> adcChanLoad && (adcChanSel == $past(lim_q[5])))
		else $error("literal not loaded into channel select");

	add_adjust_a: assert property (@(posedge clock) disable iff (!rstn) // [RQ9]
		exec && isAdd && (opt == 4'h2) |=> lim_q[2] == 16'($past(lim_q[2]) + $past(adj_q)))
		else $error("adjust value not added to timer 0 limit");

	copy_hold_a: assert property (@(posedge clock) disable iff (!rstn) // [RQ10]
		exec && isCopy |=> lim_q[step_q[2:0]] == $past(hold_q))
		else $error("hold value not copied to target");

	delay_off_a: assert property (@(posedge clock) disable iff (!rstn) // [RQ4]
		exec && isCtrl && (opt == 4'h2) |=> !sdEn_q && (state_q == ST_IDLE))
		else $error("step delay still active after disable");

	timer_wait_a: assert property (@(posedge clock) disable iff (!rstn) // [RQ5]
		exec && isCtrl && (opt == 4'h8) && (lim_q[2] == 16'h0003)
		|=> (state_q == ST_WAIT_TMR) [*4] ##1 (state_q != ST_WAIT_TMR))
		else $error("timer wait length wrong");

	swt_hold_a: assert property (@(posedge clock) disable iff (!rstn) // [RQ6]
		(state_q == ST_WAIT_SWT) && !(swt_q && !swtPrev_q) |=> state_q == ST_WAIT_SWT)
		else $error("software trigger wait left without rising bit");

	edge_hold_a: assert property (@(posedge clock) disable iff (!rstn) // [RQ2]
		(state_q == ST_WAIT_EDGE) && !edgeHit |=> state_q == ST_WAIT_EDGE)
		else $error("edge wait left without selected edge");

	reserved_nop_a: assert property (@(posedge clock) disable iff (!rstn) // [RQ11]
		exec && (cmd == 4'h6) |=> (trigOut == 32'h0) && (seqIrq == 4'h0) && !adcChanLoad
		&& $stable(lim_q[0]) && (state_q != ST_EXEC))
		else $error("reserved command changed state");
endmodule

// ==== testbench/tsq_periph_model.sv ====
`timescale 1ns/100ps
// Peripheral event sources behind the wait inputs
module tsq_periph_model (
	input  wire logic        clock,   // Peripheral clock
	input  wire logic        req,     // Start one event
	input  wire logic [3:0]  idx,     // Source line to move
	input  wire logic        pulse,   // Return the line after three cycles
	input  wire logic [3:0]  dly,     // Cycles before the edge
	output logic      [15:0] waitSrc  // Event lines, active high
);
	logic [15:0] lines = 16'h0000;
	assign waitSrc = lines;
	// Edges land off the clock edge, as from an unrelated peripheral
	always @(posedge clock) begin
		logic [3:0] i;
		i = idx;
		if (req) begin
			repeat (dly) @(posedge clock);
			#1 lines[i] = ~lines[i];
			if (pulse) begin
				repeat (3) @(posedge clock);
				#1 lines[i] = ~lines[i];
			end
		end
	end
endmodule

// ==== testbench/tsq_sequencer_bench.sv ====
`timescale 1ns/100ps
module tsq_sequencer_bench;
	import tsq_pkg::*;
	logic        clock   = 1'b0;
	logic        rstn    = 1'b0;
	logic [31:0] haddr   = 32'h0;
	logic [1:0]  htrans  = 2'h0;
	logic        hwrite  = 1'b0;
	logic [31:0] hwdata  = 32'h0;
	logic        evReq   = 1'b0;
	logic [3:0]  evIdx   = 4'h0;
	logic        evPulse = 1'b0;
	logic [3:0]  evDly   = 4'h0;
	wire         hready;
	wire         hresp;
	wire  [31:0] hrdata;
	wire  [15:0] waitSrc;
	wire  [31:0] trigOut;
	wire  [3:0]  seqIrq;
	tsq_word_t   adcChanSel;
	wire         adcChanLoad;
	int          error_cnt = 0;
	int          samples_checked = 0;
	logic [31:0] r;
	logic [7:0]  rsv [12] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h07,
		8'h0a, 8'h16, 8'h17, 8'h1e, 8'h1f, 8'h60};
	// Clock at 250 MHz
	always #2 clock = ~clock;
	tsq_sequencer i_tsq_sequencer (.clock(clock), .rstn(rstn), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
		.hrdata(hrdata), .waitSrc(waitSrc), .trigOut(trigOut), .seqIrq(seqIrq),
		.adcChanSel(adcChanSel), .adcChanLoad(adcChanLoad));
	tsq_periph_model i_tsq_periph_model (.clock(clock), .req(evReq), .idx(evIdx),
		.pulse(evPulse), .dly(evDly), .waitSrc(waitSrc));
	task automatic final_report();
		if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One single AHB-Lite transfer; the master never assumes a latency
	task automatic busXf(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clock);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge clock);
		while (hready !== 1'b1) @(posedge clock);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clock);
		while (hready !== 1'b1) @(posedge clock);
		q = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		busXf(1'b1, a, d, q);
	endtask
	task automatic rdChk(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] q;
		busXf(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	// Pulses stand for the one cycle after the execute cycle
	task automatic stepChk(input logic [7:0] b, input logic [31:0] t,
		input logic [3:0] q, input logic l);
		wr(32'h8, {24'h0, b});
		@(posedge clock);
		#1;
		chk(trigOut, t);
		chk({27'h0, seqIrq, adcChanLoad}, {27'h0, q, l});
	endtask
	task automatic waitIdle();
		logic [31:0] s;
		s = 32'h1;
		for (int k = 0; k < 100 && s !== 32'h0; k++) busXf(1'b0, 32'h4, 32'h0, s);
		chk(s, 32'h0);
	endtask
	task automatic ev(input logic [3:0] i, input logic p, input logic [3:0] d);
		evIdx <= i;
		evPulse <= p;
		evDly <= d;
		evReq <= 1'b1;
		@(posedge clock);
		evReq <= 1'b0;
	endtask
	// Edge wait: a wrong source must not release, the selected one must
	task automatic edgeWait(input logic [7:0] b);
		wr(32'h8, {24'h0, b});
		ev(b[3:0] ^ 4'h1, 1'b1, b[3:0]);
		repeat (24) @(posedge clock);
		rdChk(32'h4, 32'h2);
		ev(b[3:0], 1'b0, b[3:0]);
		repeat (24) @(posedge clock);
		rdChk(32'h4, 32'h0);
	endtask
	// Watchdog, well beyond the expected run
	initial begin
		#100000;
		error_cnt++;
		final_report();
	end
	initial begin
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		#1;
		chk(trigOut, 32'h0);
		chk({11'h0, seqIrq, adcChanLoad, adcChanSel}, 32'h0);
		chk({30'h0, hready, hresp}, 32'h2);
		for (int a = 0; a <= 32'h3c; a += 4) rdChk(a, 32'h0);
		// Unmapped places take no write and read zero
		wr(32'h3c, 32'hffffffff);
		wr(32'h100, 32'hffffffff);
		rdChk(32'h3c, 32'h0);
		rdChk(32'h100, 32'h0);
		rdChk(32'h0, 32'h0);
		for (int t = 0; t < 32; t++) stepChk(8'h80 + t, 32'h1 << t, 4'h0, 1'b0);
		for (int i = 0; i < 16; i++) stepChk(8'h70 + i, 32'h0, (i < 4) ? 4'h1 << i : 4'h0, 1'b0);
		wr(32'hc, 32'h3);
		wr(32'h10, 32'h1234);
		for (int i = 0; i < 6; i++) wr(32'h14 + 4 * i, 32'h10 + i);
		for (int i = 0; i < 6; i++) stepChk(8'h10 + i, 32'h0, 4'h0, 1'b0);
		for (int i = 0; i < 6; i++) rdChk(32'h14 + 4 * i, 32'h13 + i);
		for (int i = 0; i < 12; i++) stepChk(rsv[i], 32'h0, 4'h0, 1'b0);
		for (int i = 0; i < 6; i++) rdChk(32'h14 + 4 * i, 32'h13 + i);
		rdChk(32'h0, 32'h0);
		rdChk(32'h38, 32'h0);
		for (int i = 0; i < 6; i++) stepChk(8'h18 + i, 32'h0, 4'h0, 1'b0);
		for (int i = 0; i < 6; i++) rdChk(32'h14 + 4 * i, 32'h1234);
		wr(32'hc, 32'hffff);
		stepChk(8'h15, 32'h0, 4'h0, 1'b0);
		rdChk(32'h28, 32'h1233);
		// Channel select loads from counter 0, counter 1, literal
		wr(32'h30, 32'h0a5a);
		wr(32'h34, 32'h05a5);
		wr(32'h28, 32'h0777);
		stepChk(8'h0c, 32'h0, 4'h0, 1'b1);
		chk({16'h0, adcChanSel}, 32'h0a5a);
		stepChk(8'h0d, 32'h0, 4'h0, 1'b1);
		chk({16'h0, adcChanSel}, 32'h05a5);
		stepChk(8'h0e, 32'h0, 4'h0, 1'b1);
		rdChk(32'h38, 32'h0777);
		wr(32'h2c, 32'ha5c30f81);
		stepChk(8'h0f, 32'ha5c30f81, 4'h0, 1'b0);
		// Timer 0 ends near 41 cycles, timer 1 near 81
		wr(32'h1c, 32'd40);
		wr(32'h20, 32'd80);
		wr(32'h8, 32'h08);
		repeat (30) @(posedge clock);
		rdChk(32'h4, 32'h3);
		repeat (30) @(posedge clock);
		rdChk(32'h4, 32'h0);
		wr(32'h8, 32'h09);
		repeat (60) @(posedge clock);
		rdChk(32'h4, 32'h3);
		waitIdle();
		// Short limit: the wait lasts limit plus one cycles
		wr(32'h1c, 32'h3);
		wr(32'h8, 32'h08);
		rdChk(32'h4, 32'h3);
		waitIdle();
		// A software bit already high must not release the wait
		wr(32'h0, 32'h1);
		wr(32'h8, 32'h0b);
		repeat (8) @(posedge clock);
		rdChk(32'h4, 32'h4);
		wr(32'h0, 32'h0);
		repeat (8) @(posedge clock);
		rdChk(32'h4, 32'h4);
		wr(32'h0, 32'h1);
		repeat (4) @(posedge clock);
		rdChk(32'h4, 32'h0);
		for (int n = 0; n < 16; n++) edgeWait(8'h40 + n);
		for (int n = 0; n < 16; n++) edgeWait(8'h50 + n);
		// Step delay on, seen after a trigger step, then off again
		wr(32'h24, 32'd20);
		stepChk(8'h06, 32'h0, 4'h0, 1'b0);
		waitIdle();
		rdChk(32'h0, 32'h3);
		stepChk(8'h81, 32'h2, 4'h0, 1'b0);
		repeat (4) @(posedge clock);
		rdChk(32'h4, 32'h5);
		waitIdle();
		stepChk(8'h02, 32'h0, 4'h0, 1'b0);
		waitIdle();
		rdChk(32'h0, 32'h1);
		stepChk(8'h81, 32'h2, 4'h0, 1'b0);
		repeat (4) @(posedge clock);
		rdChk(32'h4, 32'h0);
		final_report();
	end
endmodule
